// ### hw/gpabc_data.sv
`timescale 1ns/1ps
module gpabc_data
  import gpabc_pkg::*;
(
  input  wire logic              pclk,    // peripheral clock, 200 MHz
  input  wire logic              presetn, // async reset, active low
  input  wire logic              psel,    // apb select
  input  wire logic              penable, // apb access phase
  input  wire logic              pwrite,  // apb direction, 1 is write
  input  wire logic [ADDR_W-1:0] paddr,   // apb byte address
  input  wire logic [DATA_W-1:0] pwdata,  // apb write data
  input  wire logic [STRB_W-1:0] pstrb,   // apb byte strobes
  output logic      [DATA_W-1:0] prdata,  // apb read data
  output logic                   pready,  // apb ready
  output logic                   pslverr, // apb error, unmapped address
  input  wire logic [PA_LO_W-1:0] dir_a,  // port A direction from controller
  input  wire logic [PA_LO_W-1:0] gpo_a,  // port A general output selected
  input  wire logic [PB_PINS-1:0] dir_b,  // port B direction
  input  wire logic [PB_PINS-1:0] gpo_b,  // port B general output selected
  input  wire logic [PC_PINS-1:0] dir_c,  // port C direction
  input  wire logic [PC_PINS-1:0] gpo_c,  // port C general output selected
  input  wire logic [PA_PINS-1:0] pa_in,  // port A pin levels
  output logic      [PA_LO_W-1:0] pa_out, // port A pin drive value
  output logic      [PA_LO_W-1:0] pa_oe,  // port A pin drive enable
  input  wire logic [PB_PINS-1:0] pb_in,  // port B pin levels
  output logic      [PB_PINS-1:0] pb_out, // port B pin drive value
  output logic      [PB_PINS-1:0] pb_oe,  // port B pin drive enable
  input  wire logic [PC_PINS-1:0] pc_in,  // port C pin levels
  output logic      [PC_PINS-1:0] pc_out, // port C pin drive value
  output logic      [PC_PINS-1:0] pc_oe   // port C pin drive enable
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [PA_LO_W-1:0] lat_a;
    logic [PB_PINS-1:0] lat_b;
    logic [PC_PINS-1:0] lat_c;
    logic [PA_PINS-1:0] smp_a;
    logic [PB_PINS-1:0] smp_b;
    logic [PC_PINS-1:0] smp_c;
    logic [DATA_W-1:0]  rdata;
    logic               err;
  } gpabc_state_t;

  gpabc_state_t st_reg;
  gpabc_state_t st_next;

  logic               setup_ph;
  logic               access_ph;
  gpabc_sel_t         sel;
  logic [REG_W-1:0]   mrg_a;
  logic [REG_W-1:0]   mrg_b;
  logic [REG_W-1:0]   mrg_c;
  logic [PA_LO_W-1:0] rd_a;
  logic [PB_PINS-1:0] rd_b;
  logic [PC_PINS-1:0] rd_c;
  logic [REG_W-1:0]   rd_val;

  // ****************************************************************
  // bus phases and decode
  // ****************************************************************
  // the read value is built in setup, so the access never waits
  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable;
  assign sel       = gpabc_decode(paddr);
  assign pready    = access_ph;

  // ****************************************************************
  // byte lane merging for the three latches
  // ****************************************************************
  // only lanes 1:0 hold register bits; strobes 3:2 have nothing to hit
  gpabc_lanes u_lanes_a (
    .old_val (st_reg.lat_a),
    .wr_val  (pwdata[REG_W-1:0]),
    .strb    (pstrb[1:0]),
    .merged  (mrg_a)
  );

  gpabc_lanes u_lanes_b (
    .old_val ({2'b00, st_reg.lat_b}),
    .wr_val  (pwdata[REG_W-1:0]),
    .strb    (pstrb[1:0]),
    .merged  (mrg_b)
  );

  gpabc_lanes u_lanes_c (
    .old_val (st_reg.lat_c),
    .wr_val  (pwdata[REG_W-1:0]),
    .strb    (pstrb[1:0]),
    .merged  (mrg_c)
  );

  // ****************************************************************
  // latch read-back, steered by direction
  // ****************************************************************
  gpabc_rdmux #(.W(PA_LO_W)) u_rd_a (
    .latch  (st_reg.lat_a),
    .level  (st_reg.smp_a[PA_LO_W-1:0]),
    .dir    (dir_a),
    .rd_val (rd_a)
  );

  gpabc_rdmux #(.W(PB_PINS)) u_rd_b (
    .latch  (st_reg.lat_b),
    .level  (st_reg.smp_b),
    .dir    (dir_b),
    .rd_val (rd_b)
  );

  gpabc_rdmux #(.W(PC_PINS)) u_rd_c (
    .latch  (st_reg.lat_c),
    .level  (st_reg.smp_c),
    .dir    (dir_c),
    .rd_val (rd_c)
  );

  // ****************************************************************
  // read value select
  // ****************************************************************
  // unused high bits are padded with zero so reserved bits read 0
  always_comb begin
    case (sel)
      SEL_PA_LO_DR: rd_val = rd_a;
      SEL_PA_HI_PR: rd_val = {12'h000, st_reg.smp_a[PA_PINS-1:PA_LO_W]};
      SEL_PA_LO_PR: rd_val = st_reg.smp_a[PA_LO_W-1:0];
      SEL_PB_DR:    rd_val = {2'b00, rd_b};
      SEL_PB_PR:    rd_val = {2'b00, st_reg.smp_b};
      SEL_PC_DR:    rd_val = rd_c;
      SEL_PC_PR:    rd_val = st_reg.smp_c;
      default:      rd_val = RSVD_ZERO;
    endcase
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    st_next = st_reg;
    // pin levels sampled every cycle, whatever the pin function
    st_next.smp_a = pa_in;
    st_next.smp_b = pb_in;
    st_next.smp_c = pc_in;
    // latch writes land at the access edge only
    if (access_ph && pwrite) begin
      case (sel)
        SEL_PA_LO_DR: st_next.lat_a = mrg_a;
        SEL_PB_DR:    st_next.lat_b = mrg_b[PB_PINS-1:0];
        SEL_PC_DR:    st_next.lat_c = mrg_c;
        default:      ; // pin level writes dropped here
      endcase
    end
    // read data and error are fixed in setup and held through access
    if (setup_ph) begin
      st_next.err   = (sel == SEL_NONE);
      st_next.rdata = RD_ZERO;
      if (!pwrite) begin
        st_next.rdata = {16'h0000, rd_val};
      end
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  // pin samples reset to 0 and take the real level one edge later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // direction and function come from the pin controller; the drive
  // enable covers only general output, other functions own the pin
  assign pa_out  = st_reg.lat_a;
  assign pb_out  = st_reg.lat_b;
  assign pc_out  = st_reg.lat_c;
  assign pa_oe   = dir_a & gpo_a;
  assign pb_oe   = dir_b & gpo_b;
  assign pc_oe   = dir_c & gpo_c;
  assign prdata  = st_reg.rdata;
  assign pslverr = access_ph & st_reg.err;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // a full write to port B shows on the pins one edge later
  pb_write_a: assert property (
    access_ph && pwrite && sel == SEL_PB_DR && pstrb[1:0] == 2'b11
    |=> pb_out == $past(pwdata[PB_PINS-1:0]))
    else $error("port B latch did not take write data");

  // no pin is driven while its direction is input
  oe_gate_a: assert property (
    ((pa_oe & ~dir_a) == '0) && ((pb_oe & ~dir_b) == '0)
    && ((pc_oe & ~dir_c) == '0))
    else $error("pin driven with input direction");

  // input bits of a latch read give the pin sampled two edges back
  rd_input_a: assert property (
    setup_ph && !pwrite && sel == SEL_PC_DR
    |=> ((prdata[PC_PINS-1:0] ^ $past(pc_in, 2)) & ~$past(dir_c)) == '0)
    else $error("input bit read did not return pin level");

  // output bits of a latch read give the stored latch
  rd_output_a: assert property (
    setup_ph && !pwrite && sel == SEL_PC_DR
    |=> ((prdata[PC_PINS-1:0] ^ $past(pc_out)) & $past(dir_c)) == '0)
    else $error("output bit read did not return latch");

  // pin level register follows the pins only
  pr_level_a: assert property (
    setup_ph && !pwrite && sel == SEL_PA_LO_PR
    |=> prdata == {16'h0000, $past(pa_in[PA_LO_W-1:0], 2)})
    else $error("port A pin level read wrong");

  // writes to pin level registers leave every latch alone
  ro_write_a: assert property (
    access_ph && pwrite
    && (sel == SEL_PB_PR || sel == SEL_PC_PR || sel == SEL_PA_LO_PR || sel == SEL_PA_HI_PR)
    |=> $stable(pa_out) && $stable(pb_out) && $stable(pc_out))
    else $error("pin level write changed a latch");

  // port B reserved bits read zero
  pb_rsvd_a: assert property (
    setup_ph && !pwrite && (sel == SEL_PB_DR || sel == SEL_PB_PR)
    |=> prdata[15:14] == 2'b00)
    else $error("port B reserved bits not zero");

  // upper port A levels sit in bits 3 to 0
  pah_level_a: assert property (
    setup_ph && !pwrite && sel == SEL_PA_HI_PR
    |=> prdata[15:4] == 12'h000
    && prdata[3:0] == $past(pa_in[PA_PINS-1:PA_LO_W], 2))
    else $error("upper port A level read wrong");

  // latches come out of reset at zero
  rst_zero_a: assert property (
    $rose(presetn) |-> pa_out == '0 && pb_out == '0 && pc_out == '0)
    else $error("latch not zero after reset");

  // a low byte write keeps the high byte
  byte_lane_a: assert property (
    access_ph && pwrite && sel == SEL_PC_DR && pstrb[1:0] == 2'b01
    |=> pc_out[15:8] == $past(pc_out[15:8])
    && pc_out[7:0] == $past(pwdata[7:0]))
    else $error("byte write touched other lane");

  // unmapped addresses answer with an error and zero data
  unmapped_addr_a: assert property (
    setup_ph && sel == SEL_NONE
    |=> pslverr && prdata == '0)
    else $error("unmapped access not refused");

  // mapped registers always answer without error
  mapped_ok_a: assert property (
    setup_ph && sel != SEL_NONE
    |=> !pslverr)
    else $error("mapped access answered with error");

  // a full write to port A reaches every low pin one edge later
  pa_write_a: assert property (
    access_ph && pwrite && sel == SEL_PA_LO_DR && pstrb[1:0] == 2'b11
    |=> pa_out == $past(pwdata[PA_LO_W-1:0]))
    else $error("port A latch did not take write data");

  // a full write to port C reaches all sixteen pins
  pc_write_a: assert property (
    access_ph && pwrite && sel == SEL_PC_DR && pstrb[1:0] == 2'b11
    |=> pc_out == $past(pwdata[PC_PINS-1:0]))
    else $error("port C latch did not take write data");

  // port B pin levels map pins 13 to 0 straight across
  pb_level_a: assert property (
    setup_ph && !pwrite && sel == SEL_PB_PR
    |=> prdata == {18'h0_0000, $past(pb_in, 2)})
    else $error("port B pin level read wrong");

  // port C pin levels fill the whole half word
  pc_level_a: assert property (
    setup_ph && !pwrite && sel == SEL_PC_PR
    |=> prdata == {16'h0000, $past(pc_in, 2)})
    else $error("port C pin level read wrong");

  // port A latch read mixes latch and pin per direction bit
  pa_readback_a: assert property (
    setup_ph && !pwrite && sel == SEL_PA_LO_DR
    |=> prdata[PA_LO_W-1:0] == (($past(pa_out) & $past(dir_a))
    | ($past(pa_in[PA_LO_W-1:0], 2) & ~$past(dir_a))))
    else $error("port A latch read mixed up pin and latch");

  // port B latch read mixes latch and pin per direction bit
  pb_readback_a: assert property (
    setup_ph && !pwrite && sel == SEL_PB_DR
    |=> prdata[PB_PINS-1:0] == (($past(pb_out) & $past(dir_b))
    | ($past(pb_in, 2) & ~$past(dir_b))))
    else $error("port B latch read mixed up pin and latch");

  // a high byte write to port B keeps the low byte
  pb_hi_lane_a: assert property (
    access_ph && pwrite && sel == SEL_PB_DR && pstrb[1:0] == 2'b10
    |=> pb_out[7:0] == $past(pb_out[7:0])
    && pb_out[PB_PINS-1:8] == $past(pwdata[PB_PINS-1:8]))
    else $error("port B byte write touched other lane");

  // a high byte write to port A keeps the low byte
  pa_hi_lane_a: assert property (
    access_ph && pwrite && sel == SEL_PA_LO_DR && pstrb[1:0] == 2'b10
    |=> pa_out[7:0] == $past(pa_out[7:0])
    && pa_out[15:8] == $past(pwdata[15:8]))
    else $error("port A byte write touched other lane");

  // upper port A pin level write is dropped like the others
  pah_write_a: assert property (
    access_ph && pwrite && sel == SEL_PA_HI_PR
    |=> $stable(pa_out))
    else $error("upper port A level write changed a latch");

endmodule : gpabc_data

// ### hw/gpabc_pkg.sv
package gpabc_pkg;

  // ****************************************************************
  // widths of ports and registers
  // ****************************************************************
  localparam int REG_W   = 16;
  localparam int PA_PINS = 20;
  localparam int PA_LO_W = 16;
  localparam int PA_HI_W = 4;
  localparam int PB_PINS = 14;
  localparam int PC_PINS = 16;
  localparam int ADDR_W  = 12;
  localparam int DATA_W  = 32;
  localparam int STRB_W  = 4;

  // ****************************************************************
  // register indexes and their byte addresses (index times four)
  // ****************************************************************
  localparam logic [31:0] IDX_PA_LO_DR = 32'hFFFE_3802;
  localparam logic [31:0] IDX_PA_HI_PR = 32'hFFFE_3810;
  localparam logic [31:0] IDX_PA_LO_PR = 32'hFFFE_3812;
  localparam logic [31:0] IDX_PB_DR    = 32'hFFFE_3882;
  localparam logic [31:0] IDX_PB_PR    = 32'hFFFE_3892;
  localparam logic [31:0] IDX_PC_DR    = 32'hFFFE_3902;
  localparam logic [31:0] IDX_PC_PR    = 32'hFFFE_3912;

  // only the low ten index bits reach the decoder; they stay distinct
  localparam logic [ADDR_W-1:0] ADR_PA_LO_DR = {IDX_PA_LO_DR[9:0], 2'b00};
  localparam logic [ADDR_W-1:0] ADR_PA_HI_PR = {IDX_PA_HI_PR[9:0], 2'b00};
  localparam logic [ADDR_W-1:0] ADR_PA_LO_PR = {IDX_PA_LO_PR[9:0], 2'b00};
  localparam logic [ADDR_W-1:0] ADR_PB_DR    = {IDX_PB_DR[9:0], 2'b00};
  localparam logic [ADDR_W-1:0] ADR_PB_PR    = {IDX_PB_PR[9:0], 2'b00};
  localparam logic [ADDR_W-1:0] ADR_PC_DR    = {IDX_PC_DR[9:0], 2'b00};
  localparam logic [ADDR_W-1:0] ADR_PC_PR    = {IDX_PC_PR[9:0], 2'b00};

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [REG_W-1:0]  RST_LATCH  = 16'h0000;
  localparam logic [REG_W-1:0]  RSVD_ZERO  = 16'h0000;
  localparam logic [DATA_W-1:0] RD_ZERO    = 32'h0000_0000;

  // ****************************************************************
  // register select
  // ****************************************************************
  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_PA_LO_DR,
    SEL_PA_HI_PR,
    SEL_PA_LO_PR,
    SEL_PB_DR,
    SEL_PB_PR,
    SEL_PC_DR,
    SEL_PC_PR
  } gpabc_sel_t;

  // address decode shared by read, write and checks
  function automatic gpabc_sel_t gpabc_decode(input logic [ADDR_W-1:0] addr);
    case (addr)
      ADR_PA_LO_DR: return SEL_PA_LO_DR;
      ADR_PA_HI_PR: return SEL_PA_HI_PR;
      ADR_PA_LO_PR: return SEL_PA_LO_PR;
      ADR_PB_DR:    return SEL_PB_DR;
      ADR_PB_PR:    return SEL_PB_PR;
      ADR_PC_DR:    return SEL_PC_DR;
      ADR_PC_PR:    return SEL_PC_PR;
      default:      return SEL_NONE;
    endcase
  endfunction : gpabc_decode

endpackage : gpabc_pkg

// ### hw/gpabc_lanes.sv
`timescale 1ns/1ps
module gpabc_lanes
  import gpabc_pkg::*;
(
  input  wire logic [REG_W-1:0] old_val, // stored register value
  input  wire logic [REG_W-1:0] wr_val,  // write data, low half word
  input  wire logic [1:0]       strb,    // byte strobes of the low half
  output logic      [REG_W-1:0] merged   // value after the write
);

  // each strobed byte lane takes new data, the other keeps its value
  for (genvar i = 0; i < 2; i++) begin : g_lane
    assign merged[8*i +: 8] = strb[i] ? wr_val[8*i +: 8] : old_val[8*i +: 8];
  end

endmodule : gpabc_lanes

// ### hw/gpabc_rdmux.sv
`timescale 1ns/1ps
module gpabc_rdmux #(
  parameter int W = 16
) (
  input  wire logic [W-1:0] latch,  // stored output latch bits
  input  wire logic [W-1:0] level,  // sampled pin levels
  input  wire logic [W-1:0] dir,    // direction, 1 is output
  output logic      [W-1:0] rd_val  // value seen by a latch read
);

  // outputs read back the latch, inputs read back the pin
  for (genvar i = 0; i < W; i++) begin : g_bit
    assign rd_val[i] = dir[i] ? latch[i] : level[i];
  end

endmodule : gpabc_rdmux

// ### sim/gpabc_pins.sv
`timescale 1ns/1ps
module gpabc_pins
  import gpabc_pkg::*;
(
  input  wire logic [PA_LO_W-1:0] pa_out, // block drive value, port A
  input  wire logic [PA_LO_W-1:0] pa_oe,  // block drive enable, port A
  input  wire logic [PB_PINS-1:0] pb_out, // block drive value, port B
  input  wire logic [PB_PINS-1:0] pb_oe,  // block drive enable, port B
  input  wire logic [PC_PINS-1:0] pc_out, // block drive value, port C
  input  wire logic [PC_PINS-1:0] pc_oe,  // block drive enable, port C
  input  wire logic [PA_PINS-1:0] ext_a,  // board level, port A
  input  wire logic [PB_PINS-1:0] ext_b,  // board level, port B
  input  wire logic [PC_PINS-1:0] ext_c,  // board level, port C
  output logic      [PA_PINS-1:0] pa_in,  // resolved pin level, port A
  output logic      [PB_PINS-1:0] pb_in,  // resolved pin level, port B
  output logic      [PC_PINS-1:0] pc_in   // resolved pin level, port C
);
  // a driven pin shows the block, an undriven one the board; no keeper
  assign pa_in = {ext_a[19:16], (pa_oe & pa_out) | (~pa_oe & ext_a[15:0])};
  assign pb_in = (pb_oe & pb_out) | (~pb_oe & ext_b);
  assign pc_in = (pc_oe & pc_out) | (~pc_oe & ext_c);
endmodule : gpabc_pins

// ### sim/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import gpabc_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, st = 32'h0000_0ab6, rd;
  logic [3:0]  pstrb = '0;
  logic [15:0] dir_a = '0, gpo_a = '0, dir_c = '0, gpo_c = '0, pa_out, pa_oe, pc_out, pc_oe;
  logic [15:0] pc_in, ext_c = '0, la = '0, lc = '0, ex, t;
  logic [13:0] dir_b = '0, gpo_b = '0, pb_out, pb_oe, pb_in, ext_b = '0, lb = '0;
  logic [19:0] pa_in, ext_a = '0;
  logic [11:0] at [8];
  logic        er, xe;
  int          err_count = 0, cmp_count = 0;
  // ****************************************************************
  // clock, design and pin side
  // ****************************************************************
  always #2.5 pclk = ~pclk;
  gpabc_data dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dir_a(dir_a), .gpo_a(gpo_a), .dir_b(dir_b),
    .gpo_b(gpo_b), .dir_c(dir_c), .gpo_c(gpo_c), .pa_in(pa_in), .pa_out(pa_out),
    .pa_oe(pa_oe), .pb_in(pb_in), .pb_out(pb_out), .pb_oe(pb_oe), .pc_in(pc_in),
    .pc_out(pc_out), .pc_oe(pc_oe));
  gpabc_pins pins_u (.pa_out(pa_out), .pa_oe(pa_oe), .pb_out(pb_out), .pb_oe(pb_oe),
    .pc_out(pc_out), .pc_oe(pc_oe), .ext_a(ext_a), .ext_b(ext_b), .ext_c(ext_c),
    .pa_in(pa_in), .pb_in(pb_in), .pc_in(pc_in));
  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  // byte lane merge, only strobed lanes change
  function automatic logic [15:0] mrg(input logic [15:0] o, d, input logic [3:0] s);
    return {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
  endfunction : mrg
  // mux of stored and sampled bits under a per-bit select
  function automatic logic [15:0] mx(input logic [15:0] l, sel, pin);
    return (sel & l) | (~sel & pin);
  endfunction : mx
  task automatic cmp(input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic summarize;
    if (err_count == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize
  // one apb transfer, held until pready is seen, then two idle cycles
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge pclk) begin
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= w ? s : 4'h0;
    end
    @(posedge pclk) penable <= 1;
    @(posedge pclk);
    // no fixed wait count: only the watchdog ends a hung transfer
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    repeat (2) @(posedge pclk);
  endtask : apb
  // expected value of one register from the shadow latches and board levels
  task automatic expect_rd(input logic [11:0] a);
    xe = 0;
    case (a)
      ADR_PA_LO_DR: ex = mx(la, dir_a, ext_a[15:0]);
      ADR_PA_HI_PR: ex = {12'h000, ext_a[19:16]};
      ADR_PA_LO_PR: ex = mx(la, dir_a & gpo_a, ext_a[15:0]);
      ADR_PB_DR:    ex = mx({2'b00, lb}, {2'b00, dir_b}, {2'b00, ext_b});
      ADR_PB_PR:    ex = mx({2'b00, lb}, {2'b00, dir_b & gpo_b}, {2'b00, ext_b});
      ADR_PC_DR:    ex = mx(lc, dir_c, ext_c);
      ADR_PC_PR:    ex = mx(lc, dir_c & gpo_c, ext_c);
      default: begin
        ex = 16'h0000;
        xe = 1;
      end
    endcase
  endtask : expect_rd
  task automatic rd_chk(input logic [11:0] a);
    apb(0, a, 32'h0000_0000, 4'h0);
    // expectation taken once the new pin settings have landed
    expect_rd(a);
    cmp(rd, {16'h0000, ex});
    cmp({31'h0, er}, {31'h0, xe});
  endtask : rd_chk
  task automatic wr_op(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    // software keeps reserved bits at zero
    if (a == ADR_PB_DR) d[15:14] = 2'b00;
    if (a == ADR_PA_HI_PR) d[15:4] = 12'h000;
    apb(1, a, d, s);
    if (a == ADR_PA_LO_DR) la = mrg(la, d[15:0], s);
    t = mrg({2'b00, lb}, d[15:0], s);
    if (a == ADR_PB_DR) lb = t[13:0];
    if (a == ADR_PC_DR) lc = mrg(lc, d[15:0], s);
    cmp({16'h0000, pa_oe & pa_out}, {16'h0000, dir_a & gpo_a & la});
    cmp({18'h0, pb_oe & pb_out}, {18'h0, dir_b & gpo_b & lb});
    cmp({16'h0000, pc_oe & pc_out}, {16'h0000, dir_c & gpo_c & lc});
  endtask : wr_op
  // ****************************************************************
  // sequence
  // ****************************************************************
  initial begin
    at = '{ADR_PA_LO_DR, ADR_PA_HI_PR, ADR_PA_LO_PR, ADR_PB_DR, ADR_PB_PR,
           ADR_PC_DR, ADR_PC_PR, 12'hFFC};
    repeat (20) @(posedge pclk);
    presetn <= 1;
    // outputs first, so latch reads show the reset value
    dir_a <= 16'hFFFF; dir_b <= 14'h3FFF; dir_c <= 16'hFFFF;
    // inputs read back as if software had enabled general input
    ext_a <= 20'hA_5C3F; ext_b <= 14'h1E5A; ext_c <= 16'h96C3;
    for (int i = 0; i < 8; i++) rd_chk(at[i]);
    wr_op(ADR_PB_DR, 32'hFFFF_FFFF, 4'hF);
    rd_chk(ADR_PB_DR);
    wr_op(ADR_PB_PR, 32'h0000_FFFF, 4'h3);
    rd_chk(ADR_PB_PR);
    for (int i = 0; i < 300; i++) begin
      st = xs(st);
      dir_a <= st[15:0]; dir_b <= st[29:16]; ext_a <= {st[3:0], st[31:16]};
      st = xs(st);
      gpo_a <= st[15:0]; gpo_b <= st[29:16]; ext_b <= st[13:0];
      st = xs(st);
      dir_c <= st[15:0]; gpo_c <= st[31:16]; ext_c <= {st[7:0], st[31:24]};
      st = xs(st);
      if (st[4]) wr_op(at[st[7:5]], st, {st[3:2], st[1:0] == 2'b00 ? 2'b11 : st[1:0]});
      else rd_chk(at[st[7:5]]);
    end
    // mid-run reset must clear every latch again
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    la = '0;
    lb = '0;
    lc = '0;
    for (int i = 0; i < 8; i++) rd_chk(at[i]);
    summarize;
  end
  // watchdog, well past the expected run length
  initial begin
    repeat (30000) @(posedge pclk);
    err_count++;
    summarize;
  end
endmodule : tb_top
